//--- rtl/mix_pkg.sv
// Shared constants for the layer mixer, its far end and the link between them.
package mix_pkg;
  // ==========================================================================
  // Stream geometry
  localparam int MIX_LAYERS = 2;
  localparam int MIX_CH_W = 8;
  localparam int MIX_CHANS = 3;
  localparam int MIX_PIX_W = MIX_CH_W * MIX_CHANS;
  localparam int MIX_ALPHA_W = 8;
  localparam bit MIX_ALPHA_EN = 1'b1;
  localparam int MIX_BEAT_W = 4;
  localparam logic [MIX_BEAT_W-1:0] MIX_PKT_LAST = 4'hF;
  localparam int MIX_FIFO_DEPTH = 4;
  localparam int MIX_FIFO_W = MIX_PIX_W + 2;
  // ==========================================================================
  // Blend arithmetic
  localparam logic [MIX_ALPHA_W-1:0] MIX_ALPHA_MAX = 8'hFF;
  localparam logic [MIX_ALPHA_W:0] MIX_ALPHA_ONE = 9'h100;
  localparam int MIX_SUM_W = 2 * MIX_ALPHA_W + 2;
  // ==========================================================================
  // Control slave map, word indices
  localparam int MIX_IDX_W = 2;
  localparam int MIX_CFG_W = 32;
  localparam logic [MIX_IDX_W-1:0] MIX_REG_CTRL = 2'h0;
  localparam logic [MIX_IDX_W-1:0] MIX_REG_STAT = 2'h1;
  localparam logic [MIX_IDX_W-1:0] MIX_REG_ALPHA = 2'h2;
  localparam int MIX_CTRL_SRC_BIT = 0;
  localparam int MIX_CTRL_LEN_LSB = 1;
  localparam logic [MIX_LAYERS-1:0] MIX_LEN_RST = 2'h3;
  localparam logic MIX_SRC_RST = 1'b1;
  localparam logic [MIX_ALPHA_W-1:0] MIX_ALPHA_RST = 8'hFF;
  localparam int MIX_STAT_W = 16;
  localparam int MIX_STAT_BUSY_BIT = 16;
endpackage

//--- rtl/mix_if.sv
// Link carrying the layer streams, the mixed stream and the control port.
`timescale 1ns/1ps
interface mix_if;
  import mix_pkg::*;
  logic [MIX_LAYERS-1:0][MIX_PIX_W-1:0] din_data;
  logic [MIX_LAYERS-1:0] din_valid;
  logic [MIX_LAYERS-1:0] din_ready;
  logic [MIX_LAYERS-1:0] din_sop;
  logic [MIX_LAYERS-1:0] din_eop;
  logic [MIX_LAYERS-1:0][MIX_ALPHA_W-1:0] alpha_data;
  logic [MIX_LAYERS-1:0] alpha_valid;
  logic [MIX_LAYERS-1:0] alpha_ready;
  logic [MIX_LAYERS-1:0] alpha_sop;
  logic [MIX_LAYERS-1:0] alpha_eop;
  logic [MIX_PIX_W-1:0] dout_data;
  logic dout_valid;
  logic dout_ready;
  logic dout_sop;
  logic dout_eop;
  logic [MIX_IDX_W-1:0] cfg_word_index;
  logic cfg_select;
  logic cfg_wr_strobe;
  logic [MIX_CFG_W-1:0] cfg_wr_bus;
  logic [MIX_CFG_W-1:0] cfg_rd_bus;

  // ==========================================================================
  // Mixer end.
  modport dev (
    input din_data, din_valid, din_sop, din_eop,
    output din_ready,
    input alpha_data, alpha_valid, alpha_sop, alpha_eop,
    output alpha_ready,
    output dout_data, dout_valid, dout_sop, dout_eop,
    input dout_ready,
    input cfg_word_index, cfg_select, cfg_wr_strobe, cfg_wr_bus,
    output cfg_rd_bus
  );

  // ==========================================================================
  // Sources, sink and control master.
  modport host (
    output din_data, din_valid, din_sop, din_eop,
    input din_ready,
    output alpha_data, alpha_valid, alpha_sop, alpha_eop,
    input alpha_ready,
    input dout_data, dout_valid, dout_sop, dout_eop,
    output dout_ready,
    output cfg_word_index, cfg_select, cfg_wr_strobe, cfg_wr_bus,
    input cfg_rd_bus
  );
endinterface

//--- rtl/mix_fifo.sv
// Shift-register FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module mix_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int CW = $clog2(D + 1);
  localparam logic [CW-1:0] FULL = CW'(D);

  logic [W-1:0] mem_r [D];
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic [CW-1:0] wr_idx;
  logic push;
  logic pop;

  // ==========================================================================
  // Occupancy. The head sits in entry 0 so the output is a flop, not a mux.
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign wr_idx = pop ? cnt_r - 1'b1 : cnt_r;
  assign out_data = mem_r[0];

  always_comb begin
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  // Ready and valid are registered from the next count, so both are honest.
  always_ff @(posedge core_clk or posedge srst) begin
    if (srst) begin
      cnt_r <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      in_ready <= (cnt_nxt != FULL);
      out_valid <= (cnt_nxt != '0);
    end
  end

  // ==========================================================================
  // Storage: shift toward the head on a pop, write at the first free slot.
  always_ff @(posedge core_clk or posedge srst) begin
    if (srst) begin
      for (int i = 0; i < D; i++) begin
        mem_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < D; i++) begin
        if (push && (i == int'(wr_idx))) begin
          mem_r[i] <= in_data;
        end else if (pop && (i < D - 1)) begin
          mem_r[i] <= mem_r[i + 1];
        end
      end
    end
  end
endmodule

//--- rtl/mix_dev.sv
// Layer mixer: gathers one beat per layer, blends them and queues the result.
//
// Operation
// - Everything changes on rising clock edges only.
// - Reset high clears state without a clock.
// - Reset is released aligned to a clock edge.
// - Layer ready high whenever a pixel fits.
// - Sources raise valid only with real data.
// - Each alpha stream has its own ready.
// - Alpha valid only on cycles carrying alpha.
// - First and last beats carry packet markers.
// - Sink raises ready when it can accept.
// - Output valid exactly when mixed data shown.
// - Every layer has its own pixel stream.
// - Control port idle while select low.
// - Control address is a word index.
// - Selected write strobe captures write data.
// - Read results come back on read bus.
// - Alpha streams only with alpha build option.
// - Background alpha stream accepted but ignored.
// - Background alpha may be tied low.
`timescale 1ns/1ps
module mix_dev import mix_pkg::*; (
  input wire logic core_clk,
  input wire logic srst,
  mix_if.dev link,
  output logic [MIX_STAT_W-1:0] usr_pkt_count,
  output logic usr_busy
);
  // ==========================================================================
  // Declarations
  logic [MIX_LAYERS-1:0][MIX_PIX_W-1:0] pix_r;
  logic [MIX_LAYERS-1:0] pix_full_r;
  logic [MIX_LAYERS-1:0] pix_full_nxt;
  logic [MIX_LAYERS-1:0] pix_take;
  logic [MIX_LAYERS-1:0] pix_rdy_r;
  logic pkt_sop_r;
  logic pkt_eop_r;
  logic [MIX_LAYERS-1:0][MIX_ALPHA_W-1:0] alp_r;
  logic [MIX_LAYERS-1:0] alp_full_r;
  logic [MIX_LAYERS-1:0] alp_full_nxt;
  logic [MIX_LAYERS-1:0] alp_take;
  logic [MIX_LAYERS-1:0] alp_rdy_r;
  logic [MIX_LAYERS-1:0] alp_need;
  logic [MIX_LAYERS-1:0] layer_en_r;
  logic src_stream_r;
  logic [MIX_ALPHA_W-1:0] static_alpha_r;
  logic [MIX_STAT_W-1:0] pkt_cnt_r;
  logic [MIX_CFG_W-1:0] rd_bus_r;
  logic [MIX_CFG_W-1:0] rd_mux;
  logic fifo_in_ready;
  logic fire;
  logic [MIX_PIX_W-1:0] mixed;
  logic [MIX_FIFO_W-1:0] fifo_out;

  // Weighted mix of one channel; an alpha of all ones counts as fully opaque.
  function automatic logic [MIX_CH_W-1:0] mix_ch(
    input logic [MIX_CH_W-1:0] bg,
    input logic [MIX_CH_W-1:0] fg,
    input logic [MIX_ALPHA_W-1:0] a
  );
    logic [MIX_ALPHA_W:0] w;
    logic [MIX_SUM_W-1:0] s;
    w = {1'b0, a} + {{MIX_ALPHA_W{1'b0}}, (a == MIX_ALPHA_MAX)};
    // Operands are widened first, so no product is cut at the width of w.
    s = MIX_SUM_W'(fg) * MIX_SUM_W'(w) + MIX_SUM_W'(bg) * MIX_SUM_W'(MIX_ALPHA_ONE - w);
    return s[MIX_CH_W +: MIX_CH_W];
  endfunction

  // ==========================================================================
  // Layer pixel streams
  // A beat moves only on valid with ready. Ready is registered from the next
  // hold state, which costs one bubble per beat but keeps the port a flop.
  always_comb begin
    for (int i = 0; i < MIX_LAYERS; i++) begin
      pix_take[i] = link.din_valid[i] & pix_rdy_r[i];
      pix_full_nxt[i] = (pix_full_r[i] & ~fire) | pix_take[i];
    end
  end

  always_ff @(posedge core_clk or posedge srst) begin
    if (srst) begin
      pix_full_r <= '0;
      pix_rdy_r <= '0;
      pix_r <= '0;
    end else begin
      pix_full_r <= pix_full_nxt;
      pix_rdy_r <= ~pix_full_nxt;
      for (int i = 0; i < MIX_LAYERS; i++) begin
        if (pix_take[i]) begin
          pix_r[i] <= link.din_data[i];
        end
      end
    end
  end

  // Packet markers follow the background layer, which sets the frame timing.
  always_ff @(posedge core_clk or posedge srst) begin
    if (srst) begin
      pkt_sop_r <= 1'b0;
      pkt_eop_r <= 1'b0;
    end else if (pix_take[0]) begin
      pkt_sop_r <= link.din_sop[0];
      pkt_eop_r <= link.din_eop[0];
    end
  end

  // ==========================================================================
  // Alpha streams
  // Layer 0 has no alpha use: its stream is drained and the value dropped.
  // Without the alpha option only the background alpha stream is still accepted, and dropped.
  always_comb begin
    for (int i = 0; i < MIX_LAYERS; i++) begin
      alp_need[i] = MIX_ALPHA_EN && (i != 0);
      alp_take[i] = link.alpha_valid[i] & alp_rdy_r[i];
      alp_full_nxt[i] = alp_need[i] & ((alp_full_r[i] & ~fire) | alp_take[i]);
    end
  end

  always_ff @(posedge core_clk or posedge srst) begin
    if (srst) begin
      alp_full_r <= '0;
      alp_rdy_r <= '0;
      alp_r <= '0;
    end else begin
      alp_full_r <= alp_full_nxt;
      for (int i = 0; i < MIX_LAYERS; i++) begin
        // Background ready stays high so a tied or idle source never stalls.
        alp_rdy_r[i] <= alp_need[i] ? ~alp_full_nxt[i] : (i == 0);
        if (alp_take[i] && alp_need[i]) begin
          alp_r[i] <= link.alpha_data[i];
        end
      end
    end
  end

  // ==========================================================================
  // Blend
  // A mixed beat leaves once every layer (and every needed alpha) is held and
  // the output queue has room.
  assign fire = (&pix_full_r) & ((alp_full_r & alp_need) == alp_need) & fifo_in_ready;

  always_comb begin
    logic [MIX_ALPHA_W-1:0] a;
    a = '0;
    mixed = pix_r[0];
    for (int l = 1; l < MIX_LAYERS; l++) begin
      a = src_stream_r ? alp_r[l] : static_alpha_r;
      if (!MIX_ALPHA_EN) begin
        a = MIX_ALPHA_MAX;
      end
      if (layer_en_r[l]) begin
        for (int c = 0; c < MIX_CHANS; c++) begin
          mixed[c*MIX_CH_W +: MIX_CH_W] = mix_ch(mixed[c*MIX_CH_W +: MIX_CH_W],
            pix_r[l][c*MIX_CH_W +: MIX_CH_W], a);
        end
      end
    end
  end

  // ==========================================================================
  // Output queue
  // The queue absorbs sink stalls; when full, fire drops and readies fall.
  mix_fifo #(
    .W(MIX_FIFO_W),
    .D(MIX_FIFO_DEPTH)
  ) u_out_q (
    .core_clk(core_clk),
    .srst(srst),
    .in_valid(fire),
    .in_ready(fifo_in_ready),
    .in_data({pkt_sop_r, pkt_eop_r, mixed}),
    .out_valid(link.dout_valid),
    .out_ready(link.dout_ready),
    .out_data(fifo_out)
  );

  // Queue head entries are flops, so these slices are registered outputs.
  assign link.dout_data = fifo_out[MIX_PIX_W-1:0];
  assign link.dout_eop = fifo_out[MIX_PIX_W];
  assign link.dout_sop = fifo_out[MIX_PIX_W+1];
  assign link.din_ready = pix_rdy_r;
  assign link.alpha_ready = alp_rdy_r;

  // ==========================================================================
  // Control slave
  // Writes land only with select and strobe both high; the index selects a
  // word, never a byte lane.
  always_ff @(posedge core_clk or posedge srst) begin
    if (srst) begin
      layer_en_r <= MIX_LEN_RST;
      src_stream_r <= MIX_SRC_RST;
      static_alpha_r <= MIX_ALPHA_RST;
    end else if (link.cfg_select && link.cfg_wr_strobe) begin
      unique case (link.cfg_word_index)
        MIX_REG_CTRL: begin
          src_stream_r <= link.cfg_wr_bus[MIX_CTRL_SRC_BIT];
          layer_en_r <= link.cfg_wr_bus[MIX_CTRL_LEN_LSB +: MIX_LAYERS];
        end
        MIX_REG_ALPHA: begin
          static_alpha_r <= link.cfg_wr_bus[MIX_ALPHA_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Read data is picked by index and registered one edge after select.
  always_comb begin
    rd_mux = '0;
    unique case (link.cfg_word_index)
      MIX_REG_CTRL: begin
        rd_mux[MIX_CTRL_SRC_BIT] = src_stream_r;
        rd_mux[MIX_CTRL_LEN_LSB +: MIX_LAYERS] = layer_en_r;
      end
      MIX_REG_STAT: begin
        rd_mux[MIX_STAT_W-1:0] = pkt_cnt_r;
        rd_mux[MIX_STAT_BUSY_BIT] = |pix_full_r;
      end
      MIX_REG_ALPHA: begin
        rd_mux[MIX_ALPHA_W-1:0] = static_alpha_r;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge srst) begin
    if (srst) begin
      rd_bus_r <= '0;
    end else if (link.cfg_select) begin
      rd_bus_r <= rd_mux;
    end
  end

  assign link.cfg_rd_bus = rd_bus_r;

  // ==========================================================================
  // Status
  // The packet counter wraps; software compares two reads to see progress.
  always_ff @(posedge core_clk or posedge srst) begin
    if (srst) begin
      pkt_cnt_r <= '0;
      usr_busy <= 1'b0;
    end else begin
      if (fire && pkt_eop_r) begin
        pkt_cnt_r <= pkt_cnt_r + 1'b1;
      end
      usr_busy <= |pix_full_nxt;
    end
  end

  assign usr_pkt_count = pkt_cnt_r;
endmodule

//--- rtl/mix_host.sv
// Far end of the mixer: layer and alpha sources, mixed sink, control master.
`timescale 1ns/1ps
module mix_host import mix_pkg::*; (
  input wire logic core_clk,
  input wire logic srst,
  mix_if.host link,
  input wire logic usr_start,
  input wire logic [MIX_LAYERS-1:0][MIX_PIX_W-1:0] usr_base,
  input wire logic [MIX_ALPHA_W-1:0] usr_alpha,
  input wire logic usr_sink_ready,
  output logic usr_pix_valid,
  output logic [MIX_PIX_W-1:0] usr_pix_data,
  output logic usr_pix_sop,
  output logic usr_pix_eop,
  input wire logic usr_cfg_req,
  input wire logic usr_cfg_write,
  input wire logic [MIX_IDX_W-1:0] usr_cfg_index,
  input wire logic [MIX_CFG_W-1:0] usr_cfg_wdata,
  output logic [MIX_CFG_W-1:0] usr_cfg_rdata,
  output logic usr_cfg_done
);
  typedef enum logic [2:0] {
    HST_IDLE = 3'b001,
    HST_SEL = 3'b010,
    HST_WAIT = 3'b100
  } mix_cfg_st_e;

  mix_cfg_st_e st_r;
  logic [MIX_LAYERS-1:0][MIX_BEAT_W-1:0] idx_r;
  logic [MIX_LAYERS-1:0][MIX_BEAT_W-1:0] aidx_r;
  logic [MIX_LAYERS-1:0] take;
  logic [MIX_LAYERS-1:0] atake;

  // ==========================================================================
  // Sources: one packet per start, valid held only while beats remain.
  // Background alpha stays tied low; the mixer ignores it anyway.
  assign take = link.din_valid & link.din_ready;
  assign atake = link.alpha_valid & link.alpha_ready;

  always_ff @(posedge core_clk or posedge srst) begin
    if (srst) begin
      idx_r <= '0;
      aidx_r <= '0;
      link.din_valid <= '0;
      link.din_data <= '0;
      link.din_sop <= '0;
      link.din_eop <= '0;
      link.alpha_valid <= '0;
      link.alpha_data <= '0;
      link.alpha_sop <= '0;
      link.alpha_eop <= '0;
    end else begin
      for (int i = 0; i < MIX_LAYERS; i++) begin
        if (usr_start && !link.din_valid[i]) begin
          idx_r[i] <= '0;
          link.din_valid[i] <= 1'b1;
          link.din_data[i] <= usr_base[i];
          link.din_sop[i] <= 1'b1;
          link.din_eop[i] <= 1'b0;
        end else if (take[i]) begin
          idx_r[i] <= idx_r[i] + 1'b1;
          link.din_valid[i] <= !link.din_eop[i];
          link.din_data[i] <= link.din_data[i] + 1'b1;
          link.din_sop[i] <= 1'b0;
          link.din_eop[i] <= (idx_r[i] + 1'b1 == MIX_PKT_LAST);
        end
        if (usr_start && !link.alpha_valid[i] && MIX_ALPHA_EN && i != 0) begin
          aidx_r[i] <= '0;
          link.alpha_valid[i] <= 1'b1;
          link.alpha_data[i] <= usr_alpha;
          link.alpha_sop[i] <= 1'b1;
          link.alpha_eop[i] <= 1'b0;
        end else if (atake[i]) begin
          aidx_r[i] <= aidx_r[i] + 1'b1;
          link.alpha_valid[i] <= !link.alpha_eop[i];
          link.alpha_sop[i] <= 1'b0;
          link.alpha_eop[i] <= (aidx_r[i] + 1'b1 == MIX_PKT_LAST);
        end
      end
    end
  end

  // ==========================================================================
  // Sink: ready follows the user a cycle late; accepted beats are shown.
  always_ff @(posedge core_clk or posedge srst) begin
    if (srst) begin
      link.dout_ready <= 1'b0;
      usr_pix_valid <= 1'b0;
      usr_pix_data <= '0;
      usr_pix_sop <= 1'b0;
      usr_pix_eop <= 1'b0;
    end else begin
      link.dout_ready <= usr_sink_ready;
      usr_pix_valid <= link.dout_valid & link.dout_ready;
      usr_pix_data <= link.dout_data;
      usr_pix_sop <= link.dout_sop;
      usr_pix_eop <= link.dout_eop;
    end
  end

  // ==========================================================================
  // Control master: select for one cycle, collect read data two edges later.
  always_ff @(posedge core_clk or posedge srst) begin
    if (srst) begin
      st_r <= HST_IDLE;
      link.cfg_select <= 1'b0;
      link.cfg_wr_strobe <= 1'b0;
      link.cfg_word_index <= '0;
      link.cfg_wr_bus <= '0;
      usr_cfg_rdata <= '0;
      usr_cfg_done <= 1'b0;
    end else begin
      usr_cfg_done <= 1'b0;
      unique case (st_r)
        HST_IDLE: begin
          if (usr_cfg_req) begin
            st_r <= HST_SEL;
            link.cfg_select <= 1'b1;
            link.cfg_wr_strobe <= usr_cfg_write;
            link.cfg_word_index <= usr_cfg_index;
            link.cfg_wr_bus <= usr_cfg_wdata;
          end
        end
        HST_SEL: begin
          st_r <= HST_WAIT;
          link.cfg_select <= 1'b0;
          link.cfg_wr_strobe <= 1'b0;
        end
        HST_WAIT: begin
          st_r <= HST_IDLE;
          usr_cfg_rdata <= link.cfg_rd_bus;
          usr_cfg_done <= 1'b1;
        end
      endcase
    end
  end
endmodule

//--- tb/mix_link_properties.sv
// Concurrent checks on the link between the mixer and its far end.
`timescale 1ns/1ps
module mix_link_properties import mix_pkg::*; (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [MIX_LAYERS-1:0] din_valid,
  input wire logic [MIX_LAYERS-1:0] din_ready,
  input wire logic [MIX_LAYERS-1:0] alpha_valid,
  input wire logic [MIX_LAYERS-1:0] alpha_ready,
  input wire logic [MIX_PIX_W-1:0] dout_data,
  input wire logic dout_valid,
  input wire logic dout_ready,
  input wire logic dout_sop,
  input wire logic dout_eop,
  input wire logic [MIX_IDX_W-1:0] cfg_word_index,
  input wire logic cfg_select,
  input wire logic cfg_wr_strobe,
  input wire logic [MIX_CFG_W-1:0] cfg_wr_bus,
  input wire logic [MIX_CFG_W-1:0] cfg_rd_bus
);
  // ==========================================================================
  // Helper state
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  logic [MIX_ALPHA_W-1:0] alpha_r;
  logic [MIX_BEAT_W-1:0] beat_r;

  // Shadow of the static alpha word, so readback can be judged without the body.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      alpha_r <= MIX_ALPHA_RST;
    end else if (cfg_select && cfg_wr_strobe && cfg_word_index == MIX_REG_ALPHA) begin
      alpha_r <= cfg_wr_bus[MIX_ALPHA_W-1:0];
    end
  end

  // Output beat position inside the current packet.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      beat_r <= '0;
    end else if (dout_valid && dout_ready) begin
      beat_r <= dout_eop ? '0 : beat_r + 1'b1;
    end
  end

  // ==========================================================================
  // Properties
  a_dout_hold_data: assert property (dout_valid && !dout_ready |=>
    dout_valid && $stable(dout_data) && $stable(dout_sop)) else $error("output beat dropped");
  a_din0_take_ready: assert property (din_valid[0] && din_ready[0] |=> !din_ready[0])
    else $error("layer 0 ready stayed high after take");
  a_din1_take_ready: assert property (din_valid[1] && din_ready[1] |=> !din_ready[1])
    else $error("layer 1 ready stayed high after take");
  a_alpha1_take_ready: assert property (alpha_valid[1] && alpha_ready[1] |=>
    !alpha_ready[1]) else $error("alpha ready stayed high after take");
  a_bg_alpha_ready: assert property (!$past(srst) |-> alpha_ready[0])
    else $error("background alpha not ready");
  a_unmapped_reads_zero: assert property (cfg_select && cfg_word_index == 2'h3 |=>
    cfg_rd_bus == '0) else $error("unmapped word read nonzero");
  a_idle_read_stable: assert property (!cfg_select |=> $stable(cfg_rd_bus))
    else $error("read bus moved while deselected");
  a_alpha_write_read: assert property (cfg_select && !cfg_wr_strobe &&
    cfg_word_index == MIX_REG_ALPHA |=> cfg_rd_bus[MIX_ALPHA_W-1:0] == alpha_r)
    else $error("alpha word readback wrong");
  a_sop_first_beat: assert property (dout_valid && dout_sop |-> beat_r == '0)
    else $error("start marker off first beat");
  a_eop_last_beat: assert property (dout_valid && dout_eop |-> beat_r == MIX_PKT_LAST)
    else $error("end marker off last beat");
endmodule

//--- tb/alpha_blend_layer_mixer_ports_tb_top.sv
// Testbench joining the mixer and its far end through the link.
`timescale 1ns/1ps
module alpha_blend_layer_mixer_ports_tb_top import mix_pkg::*;;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic usr_start = 1'b0;
  logic [MIX_LAYERS-1:0][MIX_PIX_W-1:0] usr_base = '0;
  logic [MIX_ALPHA_W-1:0] usr_alpha = '0;
  logic usr_sink_ready = 1'b1;
  logic usr_cfg_req = 1'b0;
  logic usr_cfg_write = 1'b0;
  logic [MIX_IDX_W-1:0] usr_cfg_index = '0;
  logic [MIX_CFG_W-1:0] usr_cfg_wdata = '0;
  logic usr_pix_valid, usr_pix_sop, usr_pix_eop, usr_cfg_done, usr_busy;
  logic [MIX_PIX_W-1:0] usr_pix_data;
  logic [MIX_CFG_W-1:0] usr_cfg_rdata;
  logic [MIX_STAT_W-1:0] usr_pkt_count;
  int fails = 0;
  int num_checks = 0;
  int pkts = 0;

  // Free-running clock, 8 ns period.
  always #4 core_clk = ~core_clk;

  mix_if mix_if_inst ();
  mix_dev mix_dev_inst (.core_clk(core_clk), .srst(srst), .link(mix_if_inst),
    .usr_pkt_count(usr_pkt_count), .usr_busy(usr_busy));
  mix_host mix_host_inst (.core_clk(core_clk), .srst(srst), .link(mix_if_inst),
    .usr_start(usr_start), .usr_base(usr_base), .usr_alpha(usr_alpha),
    .usr_sink_ready(usr_sink_ready), .usr_pix_valid(usr_pix_valid),
    .usr_pix_data(usr_pix_data), .usr_pix_sop(usr_pix_sop), .usr_pix_eop(usr_pix_eop),
    .usr_cfg_req(usr_cfg_req), .usr_cfg_write(usr_cfg_write), .usr_cfg_index(usr_cfg_index),
    .usr_cfg_wdata(usr_cfg_wdata), .usr_cfg_rdata(usr_cfg_rdata), .usr_cfg_done(usr_cfg_done));
  mix_link_properties mix_link_properties_inst (.core_clk(core_clk), .srst(srst),
    .din_valid(mix_if_inst.din_valid), .din_ready(mix_if_inst.din_ready),
    .alpha_valid(mix_if_inst.alpha_valid), .alpha_ready(mix_if_inst.alpha_ready),
    .dout_data(mix_if_inst.dout_data), .dout_valid(mix_if_inst.dout_valid),
    .dout_ready(mix_if_inst.dout_ready), .dout_sop(mix_if_inst.dout_sop),
    .dout_eop(mix_if_inst.dout_eop), .cfg_word_index(mix_if_inst.cfg_word_index),
    .cfg_select(mix_if_inst.cfg_select), .cfg_wr_strobe(mix_if_inst.cfg_wr_strobe),
    .cfg_wr_bus(mix_if_inst.cfg_wr_bus), .cfg_rd_bus(mix_if_inst.cfg_rd_bus));

  // ==========================================================================
  // Shared tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    if (fails == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic hang();
    fails++;
    finish_test();
  endtask

  // Per channel blend; full scale alpha is widened so the top layer wins outright.
  function automatic logic [MIX_PIX_W-1:0] blend(input logic [MIX_PIX_W-1:0] b, f,
                                                  input logic [7:0] a);
    logic [MIX_PIX_W-1:0] r;
    logic [8:0] w;
    int s;
    w = (a == 8'hFF) ? 9'h100 : {1'b0, a};
    for (int c = 0; c < MIX_CHANS; c++) begin
      s = f[c*8 +: 8] * w + b[c*8 +: 8] * (9'h100 - w);
      r[c*8 +: 8] = s[15:8];
    end
    return r;
  endfunction

  // One control transfer through the far end; waits for its done pulse.
  task automatic cfg(input logic wr, input logic [1:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    @(negedge core_clk);
    usr_cfg_req = 1'b1;
    usr_cfg_write = wr;
    usr_cfg_index = idx;
    usr_cfg_wdata = wd;
    @(negedge core_clk);
    usr_cfg_req = 1'b0;
    n = 0;
    while (usr_cfg_done !== 1'b1) begin
      if (n++ > 20) hang();
      @(negedge core_clk);
    end
    rd = usr_cfg_rdata;
  endtask

  // One 16-beat packet; the sink may stall until the queue backs up to the inputs.
  task automatic pkt(input logic [7:0] a_in, a_exp, input logic on, stall);
    logic [MIX_PIX_W-1:0] b, f;
    int k, n;
    b = 24'h102030;
    f = 24'h60A0E0;
    @(negedge core_clk);
    usr_base[0] = b;
    usr_base[1] = f;
    usr_alpha = a_in;
    usr_sink_ready = !stall;
    usr_start = 1'b1;
    @(negedge core_clk);
    usr_start = 1'b0;
    k = 0;
    n = 0;
    while (k < 16) begin
      if (usr_pix_valid === 1'b1) begin
        check("pix data", usr_pix_data,
              on ? blend(b + 24'(k), f + 24'(k), a_exp) : b + 24'(k));
        check("pix sop", usr_pix_sop, k == 0);
        check("pix eop", usr_pix_eop, k == 15);
        k++;
      end
      if (stall && n == 40) begin
        check("full ready", mix_if_inst.din_ready, 2'h0);
        check("busy held", usr_busy, 1'b1);
        usr_sink_ready = 1'b1;
      end
      if (n++ > 400) hang();
      @(negedge core_clk);
    end
    pkts++;
    check("pkt count", usr_pkt_count, pkts);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_regs();
    logic [31:0] rd;
    cfg(1'b0, MIX_REG_CTRL, '0, rd);
    check("ctrl reset", rd, 32'h7);
    cfg(1'b0, MIX_REG_ALPHA, '0, rd);
    check("alpha reset", rd, 32'hFF);
    cfg(1'b1, 2'h3, 32'hFFFFFFFF, rd);
    cfg(1'b0, 2'h3, '0, rd);
    check("unmapped", rd, 32'h0);
    cfg(1'b1, MIX_REG_ALPHA, 32'h40, rd);
    cfg(1'b0, MIX_REG_ALPHA, '0, rd);
    check("alpha word", rd, 32'h40);
  endtask

  task automatic t_stream();
    pkt(8'h80, 8'h80, 1'b1, 1'b0);
    pkt(8'hFF, 8'hFF, 1'b1, 1'b0);
  endtask

  task automatic t_stall();
    pkt(8'h00, 8'h00, 1'b1, 1'b1);
  endtask

  // Static alpha from the register, then the upper layer switched off.
  task automatic t_static();
    logic [31:0] rd;
    cfg(1'b1, MIX_REG_CTRL, 32'h6, rd);
    pkt(8'h80, 8'h40, 1'b1, 1'b0);
    cfg(1'b1, MIX_REG_CTRL, 32'h2, rd);
    pkt(8'h80, 8'h40, 1'b0, 1'b0);
    cfg(1'b0, MIX_REG_STAT, '0, rd);
    check("stat count", rd, pkts);
  endtask

  // Reset raised between edges must clear the readies before any edge.
  task automatic t_async();
    logic [31:0] rd;
    check("idle ready", mix_if_inst.din_ready, 2'h3);
    check("idle busy", usr_busy, 1'b0);
    @(negedge core_clk);
    srst = 1'b1;
    #1;
    check("async ready", mix_if_inst.din_ready, 2'h0);
    repeat (8) @(negedge core_clk);
    srst = 1'b0;
    cfg(1'b0, MIX_REG_ALPHA, '0, rd);
    check("alpha after reset", rd, 32'hFF);
  endtask

  // Main sequence.
  initial begin
    repeat (8) @(negedge core_clk);
    srst = 1'b0;
    t_regs();
    t_stream();
    t_stall();
    t_static();
    t_async();
    finish_test();
  end
endmodule
